// file: dv/psp_sysctl_model.sv
// system controller model driving the port mode pins
`default_nettype none
module psp_sysctl_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // bench requests
   input wire logic port_power_allocation_i,
   input wire logic peer_heavy_i,
   input wire logic [1:0] req_mode_i,
   // port side
   input wire logic load_detect_i,
   output logic mode_select_a_o,
   output logic mode_select_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import psp_pkg::*;
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   // demote while peer is heavy and this port is light, restore when peer drops
   always_comb begin
      mode_next = req_mode_i;
      if (port_power_allocation_i) begin
         mode_next = (peer_heavy_i && !load_detect_i) ? MODE_LOW_STD : MODE_CHARGE;
      end
   end
   // mode pins change just after an edge
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_reg <= MODE_RST;
      end else begin
         mode_reg <= mode_next;
      end
   end
   assign mode_select_a_o = mode_reg[1];
   assign mode_select_b_o = mode_reg[0];
endmodule
`default_nettype wire

// file: dv/tb_psp_ctrl.sv
// self-checking testbench of the port power sequencer
`default_nettype none
module tb_psp_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import psp_pkg::*;
   localparam int unsigned A_CYC = 8;
   localparam int unsigned R_CYC = 12;
   logic ref_clk_i, rstn_i, sup, en, osel, alloc_on, peer, ma, mb;
   logic sw, cc, hl, dsw, dds, ld, fo, foe;
   logic [1:0] req;
   psp_sense_t sn;
   psp_disch_t od;
   int fail_count, checks_done;
   // device under test and its controller
   psp_ctrl #(.ASSERT_CYC(A_CYC), .RELEASE_CYC(R_CYC), .DISCH_CYC(4)) u_psp_ctrl (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .input_supply_present_i(sup), .enable_i(en),
      .mode_select_a_i(ma), .mode_select_b_i(mb), .overvoltage_threshold_select_i(osel),
      .sense_i(sn), .power_switch_on_o(sw), .constant_current_o(cc), .high_current_limit_o(hl),
      .data_switch_on_o(dsw), .data_discharge_on_o(dds), .out_discharge_o(od),
      .load_detect_o(ld), .fault_out_o(fo), .fault_oe_o(foe));
   psp_sysctl_model u_psp_sysctl_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .port_power_allocation_i(alloc_on), .peer_heavy_i(peer),
      .req_mode_i(req), .load_detect_i(ld),
      .mode_select_a_o(ma), .mode_select_b_o(mb));
   // *****************
   // helpers
   // *****************
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_dis(input psp_disch_t exp);
      checks_done++;
      if (od !== exp) begin
         fail_count++;
         $display("ERROR discharge expected %b seen %b", exp, od);
      end
   endtask
   task automatic wait_sw(input logic v);
      for (int i = 0; i < 40 && sw !== v; i++) step(1);
   endtask
   // watch the switch stay closed for n cycles
   task automatic hold_on(input int n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(1);
         if (sw !== 1'b1) ok = 1'b0;
      end
      chk_bit("switch held", 1'b1, ok);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // *****************
   // scenarios
   // *****************
   task automatic t_mode;
      step(3);
      chk_bit("client switch", 1'b0, sw);
      chk_bit("client data", 1'b1, dsw);
      @(posedge ref_clk_i);
      req <= MODE_STD;
      for (int i = 0; i < 10 && od !== 3'h4; i++) step(1);
      chk_dis(3'h4);
      chk_bit("disch switch", 1'b0, sw);
      chk_bit("disch data", 1'b0, dsw);
      wait_sw(1'b1);
      chk_dis(DISCH_NONE);
      chk_bit("std limit", 1'b0, hl);
   endtask
   task automatic t_alloc;
      @(posedge ref_clk_i);
      alloc_on <= 1'b1;
      step(3);
      wait_sw(1'b1);
      chk_bit("chg limit", 1'b1, hl);
      @(posedge ref_clk_i);
      sn.load_above_assert <= 1'b1;
      step(4);
      @(posedge ref_clk_i);
      sn.load_above_assert <= 1'b0;
      step(2);
      chk_bit("ld early", 1'b0, ld);
      @(posedge ref_clk_i);
      sn.load_above_assert <= 1'b1;
      step(A_CYC - 2);
      chk_bit("ld before time", 1'b0, ld);
      step(5);
      chk_bit("ld set", 1'b1, ld);
      @(posedge ref_clk_i);
      peer <= 1'b1;
      sn.load_above_assert <= 1'b0;
      sn.load_below_release <= 1'b1;
      step(R_CYC - 4);
      chk_bit("ld held", 1'b1, ld);
      hold_on(16);
      chk_bit("ld clear", 1'b0, ld);
      chk_bit("demoted limit", 1'b0, hl);
      @(posedge ref_clk_i);
      peer <= 1'b0;
      hold_on(6);
      chk_bit("restored limit", 1'b1, hl);
   endtask
   task automatic t_ov;
      @(posedge ref_clk_i);
      sn.connector_data_plus_ov <= 1'b1;
      step(2);
      chk_bit("dp data sw", 1'b0, dsw);
      chk_bit("dp disch", 1'b1, dds);
      @(posedge ref_clk_i);
      sn.connector_data_plus_ov <= 1'b0;
      sn.connector_data_minus_ov <= 1'b1;
      step(2);
      chk_bit("dm disch", 1'b1, dds);
      @(posedge ref_clk_i);
      sn.connector_data_minus_ov <= 1'b0;
      step(2);
      chk_bit("data sw back", 1'b1, dsw);
      chk_bit("disch gone", 1'b0, dds);
      wait_sw(1'b1);
      @(posedge ref_clk_i);
      osel <= 1'b1;
      sn.vout_above_6v0 <= 1'b1;
      step(2);
      chk_bit("high sel", 1'b1, sw);
      @(posedge ref_clk_i);
      osel <= 1'b0;
      step(2);
      chk_bit("bus ov sw", 1'b0, sw);
      chk_dis(3'h2);
      @(posedge ref_clk_i);
      sn.vout_above_6v0 <= 1'b0;
      step(2);
      chk_bit("bus ov clear", 1'b1, sw);
      chk_dis(DISCH_NONE);
      @(posedge ref_clk_i);
      en <= 1'b0;
      step(2);
      chk_dis(3'h4);
      @(posedge ref_clk_i);
      sup <= 1'b0;
      sn.vout_above_6v0 <= 1'b1;
      step(2);
      chk_dis(3'h1);
      // lockout alone must hold the switch open, so enable is back on here
      @(posedge ref_clk_i);
      sup <= 1'b1;
      en <= 1'b1;
      sn.vout_above_6v0 <= 1'b0;
      sn.undervoltage_lockout <= 1'b1;
      step(2);
      chk_bit("lockout off", 1'b0, sw);
      @(posedge ref_clk_i);
      en <= 1'b0;
      sn.overcurrent <= 1'b1;
      sn.undervoltage_lockout <= 1'b0;
      @(posedge ref_clk_i);
      en <= 1'b1;
      wait_sw(1'b1);
      chk_bit("short at enable", 1'b1, cc);
   endtask
   task automatic t_therm;
      @(posedge ref_clk_i);
      sn.temp_above_135 <= 1'b1;
      step(2);
      chk_bit("lower trip", 1'b0, sw);
      chk_bit("fault pin", 1'b1, foe);
      chk_bit("fault level", 1'b0, fo);
      @(posedge ref_clk_i);
      sn.temp_above_135 <= 1'b0;
      step(2);
      chk_bit("not cooled", 1'b0, sw);
      @(posedge ref_clk_i);
      sn.temp_cooled <= 1'b1;
      sn.overcurrent <= 1'b0;
      step(2);
      wait_sw(1'b1);
      chk_bit("reclosed", 1'b1, sw);
      chk_bit("fault off", 1'b0, foe);
      @(posedge ref_clk_i);
      sn.temp_cooled <= 1'b0;
      sn.temp_above_135 <= 1'b1;
      step(2);
      chk_bit("no limit trip", 1'b1, sw);
      @(posedge ref_clk_i);
      sn.temp_above_135 <= 1'b0;
      sn.temp_above_155 <= 1'b1;
      step(2);
      chk_bit("upper trip", 1'b0, sw);
   endtask
   // clock, reset and run
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      {rstn_i, osel, alloc_on, peer, req, sn} = '0;
      {sup, en} = 2'h3;
      repeat (6) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_mode();
      t_alloc();
      t_ov();
      t_therm();
      give_verdict();
   end
   // watchdog against a hang
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end
endmodule
`default_nettype wire

// file: hw/psp_ctrl.sv
// control and protection sequencer of the usb port power switch
`default_nettype none
module psp_ctrl #(
   parameter int unsigned ASSERT_CYC = psp_pkg::LD_ASSERT_CYC,
   parameter int unsigned RELEASE_CYC = psp_pkg::LD_RELEASE_CYC,
   parameter int unsigned DISCH_CYC = psp_pkg::MODE_DISCH_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // control pins
   input wire logic input_supply_present_i,
   input wire logic enable_i,
   input wire logic mode_select_a_i,
   input wire logic mode_select_b_i,
   input wire logic overvoltage_threshold_select_i,
   // analog comparator results
   input wire psp_pkg::psp_sense_t sense_i,
   // switch controls
   output logic power_switch_on_o,
   output logic constant_current_o,
   output logic high_current_limit_o,
   output logic data_switch_on_o,
   output logic data_discharge_on_o,
   output psp_pkg::psp_disch_t out_discharge_o,
   // status pins
   output logic load_detect_o,
   output logic fault_out_o,
   output logic fault_oe_o
);
   import psp_pkg::*;

   // ***********************************
   // declarations
   // ***********************************
   psp_state_t state_reg, state_next;
   logic [1:0] mode_reg, mode_next;
   logic [CNT_W-1:0] disch_cnt_reg, disch_cnt_next;
   logic [CNT_W-1:0] asrt_cnt_reg, asrt_cnt_next;
   logic [CNT_W-1:0] rel_cnt_reg, rel_cnt_next;
   logic ld_reg, ld_next;
   logic thermal_reg, thermal_next;
   logic pwr_reg, pwr_next;
   logic cc_reg, cc_next;
   logic hi_reg, hi_next;
   logic dsw_reg, dsw_next;
   logic ddis_reg, ddis_next;
   psp_disch_t odis_reg, odis_next;
   logic [1:0] mode_in;
   logic bus_ov, data_ov, mode_skip;

   // true for a direct step between codes 10 and 11
   function automatic logic skip_pair(input logic [1:0] a, input logic [1:0] b);
      skip_pair = (a[1] & b[1]) & (a[0] ^ b[0]);
   endfunction

   // ***********************************
   // condition decode
   // ***********************************
   assign mode_in = {mode_select_a_i, mode_select_b_i};
   assign bus_ov = overvoltage_threshold_select_i ? sense_i.vout_above_6v95
                                                  : sense_i.vout_above_6v0;
   assign data_ov = sense_i.connector_data_plus_ov | sense_i.connector_data_minus_ov;
   assign mode_skip = skip_pair(mode_reg, mode_in);

   // mode change sequencer
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      disch_cnt_next = disch_cnt_reg;
      case (state_reg)
         ST_RUN: begin
            if (mode_in != mode_reg) begin
               mode_next = mode_in;
               disch_cnt_next = '0;
               if (!mode_skip) begin
                  state_next = ST_DISCH;
               end
            end
         end
         ST_DISCH: begin
            if (mode_in != mode_reg) begin
               mode_next = mode_in;
               disch_cnt_next = '0;
            end else if (disch_cnt_reg == CNT_W'(DISCH_CYC - 1)) begin
               state_next = ST_RUN;
            end else begin
               disch_cnt_next = disch_cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= ST_RUN;
         mode_reg <= MODE_RST;
         disch_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         disch_cnt_reg <= disch_cnt_next;
      end
   end

   // thermal trip, switch and discharge selection
   always_comb begin
      thermal_next = thermal_reg;
      if (sense_i.temp_above_155 || (sense_i.temp_above_135 && cc_reg)) begin
         thermal_next = 1'b1;
      end else if (sense_i.temp_cooled) begin
         thermal_next = 1'b0;
      end
      pwr_next = input_supply_present_i && !sense_i.undervoltage_lockout
                 && enable_i && (mode_reg != MODE_CLIENT) && !bus_ov
                 && !data_ov && !thermal_next && (state_next == ST_RUN);
      cc_next = pwr_next && sense_i.overcurrent;
      hi_next = (mode_reg == MODE_CHARGE);
      dsw_next = enable_i && !data_ov && (state_next == ST_RUN);
      ddis_next = data_ov;
      odis_next = DISCH_NONE;
      if (!input_supply_present_i) begin
         odis_next.r80k = bus_ov;
      end else if (!enable_i || state_next == ST_DISCH) begin
         odis_next.r500 = 1'b1;
      end else begin
         odis_next.r55k = bus_ov;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         thermal_reg <= 1'b0;
         pwr_reg <= 1'b0;
         cc_reg <= 1'b0;
         hi_reg <= 1'b0;
         dsw_reg <= 1'b0;
         ddis_reg <= 1'b0;
         odis_reg <= DISCH_NONE;
      end else begin
         thermal_reg <= thermal_next;
         pwr_reg <= pwr_next;
         cc_reg <= cc_next;
         hi_reg <= hi_next;
         dsw_reg <= dsw_next;
         ddis_reg <= ddis_next;
         odis_reg <= odis_next;
      end
   end

   // load detect qualification timers
   always_comb begin
      asrt_cnt_next = '0;
      rel_cnt_next = '0;
      ld_next = ld_reg;
      if (mode_reg != MODE_CHARGE) begin
         ld_next = 1'b0;
      end else if (!ld_reg) begin
         if (sense_i.load_above_assert) begin
            if (asrt_cnt_reg == CNT_W'(ASSERT_CYC - 1)) begin
               ld_next = 1'b1;
            end else begin
               asrt_cnt_next = asrt_cnt_reg + 1'b1;
            end
         end
      end else if (sense_i.load_below_release) begin
         if (rel_cnt_reg == CNT_W'(RELEASE_CYC - 1)) begin
            ld_next = 1'b0;
         end else begin
            rel_cnt_next = rel_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         asrt_cnt_reg <= '0;
         rel_cnt_reg <= '0;
         ld_reg <= 1'b0;
      end else begin
         asrt_cnt_reg <= asrt_cnt_next;
         rel_cnt_reg <= rel_cnt_next;
         ld_reg <= ld_next;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign power_switch_on_o = pwr_reg;
   assign constant_current_o = cc_reg;
   assign high_current_limit_o = hi_reg;
   assign data_switch_on_o = dsw_reg;
   assign data_discharge_on_o = ddis_reg;
   assign out_discharge_o = odis_reg;
   assign load_detect_o = ld_reg;
   assign fault_out_o = 1'b0;
   assign fault_oe_o = thermal_reg;

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_threshold_select: assert property (
      (!overvoltage_threshold_select_i && sense_i.vout_above_6v0 && input_supply_present_i
       && enable_i && state_reg == ST_RUN && mode_in == mode_reg)
      |=> (out_discharge_o.r55k && !power_switch_on_o))
      else $error("low overvoltage threshold ignored");
   a_disch_hold: assert property (
      (state_reg == ST_RUN && mode_in != mode_reg && !mode_skip && input_supply_present_i)
      |=> (!power_switch_on_o && !data_switch_on_o && out_discharge_o.r500)[*2])
      else $error("mode change discharge missing");
   a_skip_pair: assert property (
      (state_reg == ST_RUN && mode_skip) |=> state_reg == ST_RUN)
      else $error("discharge on 10/11 step");
   a_data_overvoltage: assert property (
      data_ov |=> (!data_switch_on_o && data_discharge_on_o && !power_switch_on_o))
      else $error("data overvoltage not handled");
   a_data_clear: assert property (
      (!data_ov && enable_i && state_next == ST_RUN)
      |=> (data_switch_on_o && !data_discharge_on_o))
      else $error("data path not restored");
   a_hot_trip: assert property (
      sense_i.temp_above_155 |=> (!power_switch_on_o && fault_oe_o && !fault_out_o))
      else $error("upper thermal trip ignored");
   a_warm_trip: assert property (
      (sense_i.temp_above_135 && !sense_i.temp_above_155 && !cc_reg && !thermal_reg)
      |=> !thermal_reg)
      else $error("lower trip without current limit");
   a_lockout_off: assert property (
      sense_i.undervoltage_lockout |=> !power_switch_on_o)
      else $error("switch on under lockout");
   a_ld_assert: assert property (
      $rose(load_detect_o) |-> $past(asrt_cnt_reg) == CNT_W'(ASSERT_CYC - 1))
      else $error("load detect asserted early");
   a_ld_release: assert property (
      ($fell(load_detect_o) && $past(mode_reg) == MODE_CHARGE)
      |-> $past(rel_cnt_reg) == CNT_W'(RELEASE_CYC - 1))
      else $error("load detect released early");
   a_limit_sel: assert property (
      (mode_reg == MODE_LOW_STD) |=> !high_current_limit_o)
      else $error("wrong current limit");

   // further checks on switch, discharge and status outputs
   a_bus_ov_off: assert property (
      bus_ov |=> !power_switch_on_o)
      else $error("switch on under bus overvoltage");
   a_unpowered_disch: assert property (
      (!input_supply_present_i && bus_ov) |=> (out_discharge_o.r80k && !out_discharge_o.r500))
      else $error("unpowered discharge path wrong");
   a_client_off: assert property (
      (mode_reg == MODE_CLIENT) |=> !power_switch_on_o)
      else $error("switch on in client mode");
   a_charge_limit: assert property (
      (mode_reg == MODE_CHARGE) |=> high_current_limit_o)
      else $error("charging port without high limit");
   a_thermal_hold: assert property (
      (fault_oe_o && !sense_i.temp_cooled) |=> (!power_switch_on_o && fault_oe_o))
      else $error("switch reclosed before cooling");
   a_ld_mode_off: assert property (
      (mode_reg != MODE_CHARGE) |=> !load_detect_o)
      else $error("load detect outside charging mode");
   a_limit_with_switch: assert property (
      constant_current_o |-> power_switch_on_o)
      else $error("current regulation with switch open");
   a_disch_data: assert property (
      (state_reg == ST_DISCH) |-> (!data_switch_on_o && !power_switch_on_o))
      else $error("switches closed during discharge");

   c_mode_disch: cover property (state_reg == ST_DISCH ##1 state_reg == ST_RUN);
   c_ld_rise: cover property ($rose(load_detect_o));
   c_thermal_cycle: cover property ($rose(fault_oe_o) ##[1:20] $fell(fault_oe_o));
   c_skip: cover property (state_reg == ST_RUN && mode_skip);
   c_unpowered_ov: cover property (!input_supply_present_i && bus_ov);
endmodule
`default_nettype wire

// file: hw/psp_pkg.sv
// constants and carrier types for the usb port power protection controller
`default_nettype none
package psp_pkg;
   // ***********************************
   // clock and timing
   // ***********************************
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned LD_ASSERT_MS = 210;   // load detect qualification time
   localparam int unsigned LD_RELEASE_S = 3;     // load detect release time
   localparam int unsigned MODE_DISCH_MS = 10;   // mode change discharge time
   localparam int unsigned LD_ASSERT_CYC = LD_ASSERT_MS * (CLK_HZ / 1000);
   localparam int unsigned LD_RELEASE_CYC = LD_RELEASE_S * CLK_HZ;
   localparam int unsigned MODE_DISCH_CYC = MODE_DISCH_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 32;

   // ***********************************
   // mode codes (select a, select b)
   // ***********************************
   localparam logic [1:0] MODE_CLIENT = 2'h0;
   localparam logic [1:0] MODE_STD = 2'h1;
   localparam logic [1:0] MODE_LOW_STD = 2'h2;   // low_limit_standard_port_mode
   localparam logic [1:0] MODE_CHARGE = 2'h3;
   localparam logic [1:0] MODE_RST = MODE_CLIENT;

   // ***********************************
   // sequencer states
   // ***********************************
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_DISCH = 2'b10
   } psp_state_t;

   // ***********************************
   // analog comparator results
   // ***********************************
   typedef struct packed {
      logic vout_above_6v0;
      logic vout_above_6v95;
      logic connector_data_plus_ov;
      logic connector_data_minus_ov;
      logic undervoltage_lockout;
      logic overcurrent;       // load above selected current limit
      logic temp_above_135;
      logic temp_above_155;
      logic temp_cooled;       // die cooled by hysteresis below trip
      logic load_above_assert; // load above low limit plus offset
      logic load_below_release; // load below low limit minus offset
   } psp_sense_t;

   // ***********************************
   // output discharge selection
   // ***********************************
   typedef struct packed {
      logic r500;
      logic r55k;
      logic r80k;
   } psp_disch_t;
   localparam psp_disch_t DISCH_NONE = 3'h0;
endpackage
`default_nettype wire
